/* File: hw/cgc_pkg.sv */
/*
  Shared constants of the clock generator control block: register addresses,
  reset values, field positions, option byte encodings and wait lengths.
  Assumes an 8-bit internal register bus with 16-bit addresses.
*/
package cgc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register addresses on the internal bus
  localparam logic [15:0] CGC_ADDR_LOWSPEED_OSC_CONTROL     = 16'hFF58;
  localparam logic [15:0] CGC_ADDR_PERIPHERAL_CLOCK_DIVIDER = 16'hFFF3;
  localparam logic [15:0] CGC_ADDR_STOP_WAKE_WAIT_SELECT    = 16'hFFF4;
  localparam logic [15:0] CGC_ADDR_CPU_CLOCK_DIVIDER        = 16'hFFFB;

  // Reset values
  localparam logic [7:0]  CGC_RST_CPU_CLOCK_DIVIDER        = 8'h02;
  localparam logic [7:0]  CGC_RST_PERIPHERAL_CLOCK_DIVIDER = 8'h02;
  localparam logic [7:0]  CGC_RST_LOWSPEED_OSC_CONTROL     = 8'h00;
  // Stand-in for the undefined reset value of the wait select field
  localparam logic [1:0]  CGC_RST_WAIT_SELECT              = 2'h3;

  // Field positions
  localparam int          CGC_CPU_DIVIDE_BIT     = 1;
  localparam int          CGC_PERIPH_DIVIDE_LOW  = 0;
  localparam int          CGC_LOWSPEED_HALT_BIT  = 0;
  localparam int          CGC_WAIT_SELECT_LOW    = 0;
  localparam logic [7:0]  CGC_FULL_BYTE          = 8'hFF;
  localparam logic [7:0]  CGC_READ_UNMAPPED      = 8'h00;

  // Peripheral divider code and CPU exponent step
  localparam logic [1:0]  CGC_PDIV_PROHIBITED    = 2'h3;
  localparam logic [2:0]  CGC_CPU_EXTRA_EXP      = 3'h2;

  // Option byte encoding of the system clock source
  localparam logic [1:0]  CGC_SRC_ON_CHIP_OSC    = 2'h0;
  localparam logic [1:0]  CGC_SRC_CRYSTAL        = 2'h1;
  localparam logic [1:0]  CGC_SRC_EXTERNAL       = 2'h2;

  // Wait lengths in system source clock periods
  localparam int unsigned CGC_WAIT_CODE0         = 1 << 10;
  localparam int unsigned CGC_WAIT_CODE1         = 1 << 12;
  localparam int unsigned CGC_WAIT_CODE2         = 1 << 15;
  localparam int unsigned CGC_WAIT_CODE3         = 1 << 17;
  localparam int          CGC_WAIT_CNT_W         = 18;

  // Prescaler counter width, covers division by 16
  localparam int          CGC_PRESCALE_W         = 4;

  // Sequencer states
  typedef enum logic [2:0] {
    CGC_ST_BOOT,
    CGC_ST_START,
    CGC_ST_WAIT,
    CGC_ST_RUN,
    CGC_ST_STOP
  } cgc_state_t;

endpackage

/* File: hw/cgc_prescaler.sv */
/*
  Prescaler: turns the system source clock into clock enables for the
  peripheral clock and the CPU clock, by power-of-two exponents.
  Assumes clk is the system source clock and the exponents are legal.
*/
`timescale 1ns/1ps
module cgc_prescaler
  import cgc_pkg::*;
(
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      sys_rst,
  // Control
  input  wire logic                      run,
  input  wire logic [2:0]                cpu_exp,
  input  wire logic [1:0]                periph_exp,
  // Clock enables
  output logic                           cpu_clk_en,
  output logic                           periph_clk_en
);

  typedef struct packed {
    logic [CGC_PRESCALE_W-1:0] cnt;
    logic                      cpu_en;
    logic                      per_en;
  } cgc_pre_state_t;

  cgc_pre_state_t cur_ff;
  cgc_pre_state_t nxt_cur;
  logic [CGC_PRESCALE_W-1:0] cpu_mask;
  logic [CGC_PRESCALE_W-1:0] per_mask;

  ////////////////////////////////////////////////////////////////////////////
  // Masks: one bit per halving, so /1 has an empty mask
  genvar gi;
  generate
    for (gi = 0; gi < CGC_PRESCALE_W; gi++) begin : g_mask
      assign cpu_mask[gi] = (cpu_exp > 3'(gi));
      assign per_mask[gi] = ({1'b0, periph_exp} > 3'(gi));
    end
  endgenerate

  // Enables fire when the masked counter wraps; held low while the clock is stopped
  always_comb begin
    nxt_cur        = cur_ff;
    nxt_cur.cnt    = run ? cur_ff.cnt + 1'b1 : '0;
    nxt_cur.cpu_en = run && ((cur_ff.cnt & cpu_mask) == '0);
    nxt_cur.per_en = run && ((cur_ff.cnt & per_mask) == '0);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign cpu_clk_en    = cur_ff.cpu_en;
  assign periph_clk_en = cur_ff.per_en;

endmodule

/* File: hw/cgc_clock_generator_control.sv */
/*
  Clock generator control: the four clock registers, divider selection,
  low-speed oscillator control, stop handling and the oscillation
  stabilization wait after reset release or stop release.
  Assumes clk is the selected system source clock, a single-master internal
  byte bus, and option byte levels that are stable while running.
*/
`timescale 1ns/1ps

// Function
// - Reset loads CPU and peripheral divider registers with 0x02.
// - CPU clock picked by peripheral bits and CPU bit; other combinations prohibited.
// - Peripheral clock is source/2 for value 0x01, source/4 for 0x02.
// - Reset clears low-speed oscillator control, so oscillator runs.
// - Low-speed control bit 0: zero runs the oscillator, one halts it.
// - Option marks oscillator unstoppable: halt bit ignored, oscillator always runs.
// - Unstoppable oscillator forces watchdog clock source to low-speed oscillator.
// - Wait select register undefined after reset; software writes it first.
// - Wait codes 00..11 give 2^10, 2^12, 2^15, 2^17 source periods.
// - Programmed wait applies only with crystal source, only on stop release.
// - On-chip or external clock source: no wait after leaving stop.
// - Wait counting starts only once the oscillator oscillates again.
// - Option byte chooses on-chip, crystal or external clock as source.
// - Wait after power-up or reset release comes from the option byte.
// - Stop halts the high-speed oscillator, crystal, or external clock feed.
module cgc_clock_generator_control
  import cgc_pkg::*;
#(
  parameter int unsigned WAIT_CNT_CODE0 = CGC_WAIT_CODE0,
  parameter int unsigned WAIT_CNT_CODE1 = CGC_WAIT_CODE1,
  parameter int unsigned WAIT_CNT_CODE2 = CGC_WAIT_CODE2,
  parameter int unsigned WAIT_CNT_CODE3 = CGC_WAIT_CODE3
) (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      sys_rst,
  // Internal register bus
  input  wire logic [15:0]               bus_addr,
  input  wire logic                      bus_wr,
  input  wire logic                      bus_rd,
  input  wire logic [7:0]                bus_wdata,
  input  wire logic [7:0]                bus_wmask,
  output logic [7:0]                     bus_rdata_ff,
  output logic                           bus_rvalid_ff,
  // Option byte levels
  input  wire logic [1:0]                opt_clk_src,
  input  wire logic                      opt_lowspeed_locked,
  input  wire logic [1:0]                opt_reset_wait_sel,
  // Stop sequencing
  input  wire logic                      stop_req,
  input  wire logic                      wake_event,
  input  wire logic                      osc_running,
  // Oscillator and clock control
  output logic                           sys_osc_halt_ff,
  output logic                           lowspeed_osc_halt_ff,
  output logic                           wdt_force_lowspeed_ff,
  output logic                           cpu_hold_ff,
  output logic                           div_prohibited_ff,
  output logic                           cpu_clk_en,
  output logic                           periph_clk_en
);

  ////////////////////////////////////////////////////////////////////////////
  // Parameter checks

  // Refused at elaboration: a zero count or one beyond the counter cannot be loaded
  if (WAIT_CNT_CODE0 < 1 || WAIT_CNT_CODE1 < 1 || WAIT_CNT_CODE2 < 1 || WAIT_CNT_CODE3 < 1 ||
      WAIT_CNT_CODE0 > (1 << CGC_WAIT_CNT_W) || WAIT_CNT_CODE1 > (1 << CGC_WAIT_CNT_W) ||
      WAIT_CNT_CODE2 > (1 << CGC_WAIT_CNT_W) || WAIT_CNT_CODE3 > (1 << CGC_WAIT_CNT_W)) begin : g_bad_wait
    $error("wait counts must lie between 1 and the counter range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    cgc_state_t                st;
    logic [CGC_WAIT_CNT_W-1:0] cnt;
    logic                      cpu_div;
    logic [1:0]                per_div;
    logic                      ls_halt;
    logic [1:0]                wait_sel;
    logic [2:0]                cpu_exp;
    logic [1:0]                per_exp;
    logic                      div_bad;
    logic [7:0]                rdata;
    logic                      rvalid;
    logic                      sys_halt;
    logic                      ls_osc_halt;
    logic                      wdt_force;
    logic                      cpu_hold;
  } cgc_ctl_state_t;

  cgc_ctl_state_t cur_ff;
  cgc_ctl_state_t nxt_cur;

  logic [7:0] rd_val;
  logic [7:0] cpu_reg;
  logic [7:0] per_reg;
  logic [7:0] ls_reg;
  logic [7:0] wait_reg;
  logic [7:0] cpu_wr;
  logic [7:0] per_wr;
  logic [7:0] ls_wr;
  logic       is_crystal;

  ////////////////////////////////////////////////////////////////////////////
  // Register images: implemented bits only, the rest read zero

  always_comb begin
    cpu_reg                         = '0;
    cpu_reg[CGC_CPU_DIVIDE_BIT]     = cur_ff.cpu_div;
    per_reg                         = '0;
    per_reg[CGC_PERIPH_DIVIDE_LOW+:2] = cur_ff.per_div;
    ls_reg                          = '0;
    ls_reg[CGC_LOWSPEED_HALT_BIT]   = cur_ff.ls_halt;
    wait_reg                        = '0;
    wait_reg[CGC_WAIT_SELECT_LOW+:2] = cur_ff.wait_sel;
  end

  // Bit writes merge under the mask, so a single-bit access leaves the rest alone
  assign cpu_wr = (cpu_reg & ~bus_wmask) | (bus_wdata & bus_wmask);
  assign per_wr = (per_reg & ~bus_wmask) | (bus_wdata & bus_wmask);
  assign ls_wr  = (ls_reg  & ~bus_wmask) | (bus_wdata & bus_wmask);

  // Read decode, unmapped addresses answer zero
  always_comb begin
    case (bus_addr)
      CGC_ADDR_CPU_CLOCK_DIVIDER:        rd_val = cpu_reg;
      CGC_ADDR_PERIPHERAL_CLOCK_DIVIDER: rd_val = per_reg;
      CGC_ADDR_LOWSPEED_OSC_CONTROL:     rd_val = ls_reg;
      CGC_ADDR_STOP_WAKE_WAIT_SELECT:    rd_val = wait_reg;
      default:                           rd_val = CGC_READ_UNMAPPED;
    endcase
  end

  assign is_crystal = (opt_clk_src == CGC_SRC_CRYSTAL);

  ////////////////////////////////////////////////////////////////////////////
  // Wait length lookup, loaded as count minus one

  function automatic logic [CGC_WAIT_CNT_W-1:0] wait_load(input logic [1:0] code);
    int unsigned n;
    case (code)
      2'h0:    n = WAIT_CNT_CODE0;
      2'h1:    n = WAIT_CNT_CODE1;
      2'h2:    n = WAIT_CNT_CODE2;
      default: n = WAIT_CNT_CODE3;
    endcase
    return CGC_WAIT_CNT_W'(n - 1);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    nxt_cur        = cur_ff;
    nxt_cur.rvalid = bus_rd;
    nxt_cur.rdata  = bus_rd ? rd_val : CGC_READ_UNMAPPED;

    // Register writes
    if (bus_wr) begin
      case (bus_addr)
        CGC_ADDR_CPU_CLOCK_DIVIDER: begin
          nxt_cur.cpu_div = cpu_wr[CGC_CPU_DIVIDE_BIT];
        end
        CGC_ADDR_PERIPHERAL_CLOCK_DIVIDER: begin
          nxt_cur.per_div = per_wr[CGC_PERIPH_DIVIDE_LOW+:2];
        end
        CGC_ADDR_LOWSPEED_OSC_CONTROL: begin
          nxt_cur.ls_halt = ls_wr[CGC_LOWSPEED_HALT_BIT];
        end
        CGC_ADDR_STOP_WAKE_WAIT_SELECT: begin
          // Partial writes here are dropped: the field only accepts whole bytes
          if (bus_wmask == CGC_FULL_BYTE) begin
            nxt_cur.wait_sel = bus_wdata[CGC_WAIT_SELECT_LOW+:2];
          end
        end
        default: begin
          nxt_cur.rvalid = bus_rd;
        end
      endcase
    end

    // Divider decode; a prohibited setting keeps the last legal ratio running
    if (nxt_cur.per_div == CGC_PDIV_PROHIBITED) begin
      nxt_cur.div_bad = 1'b1;
    end else begin
      nxt_cur.div_bad = 1'b0;
      nxt_cur.per_exp = nxt_cur.per_div;
      nxt_cur.cpu_exp = {1'b0, nxt_cur.per_div} +
                        (nxt_cur.cpu_div ? CGC_CPU_EXTRA_EXP : 3'h0);
    end

    // Low-speed oscillator: a locked option overrides the halt bit
    nxt_cur.ls_osc_halt = nxt_cur.ls_halt && !opt_lowspeed_locked;
    nxt_cur.wdt_force   = opt_lowspeed_locked;

    // Stop and stabilization sequencer
    case (cur_ff.st)
      CGC_ST_BOOT: begin
        // First edge after reset release decides the start path
        if (is_crystal) begin
          nxt_cur.st  = CGC_ST_START;
          nxt_cur.cnt = wait_load(opt_reset_wait_sel);
        end else begin
          nxt_cur.st  = CGC_ST_RUN;
        end
      end
      CGC_ST_START: begin
        // Oscillator startup time is not part of the wait
        if (osc_running) begin
          nxt_cur.st = CGC_ST_WAIT;
        end
      end
      CGC_ST_WAIT: begin
        if (cur_ff.cnt == '0) begin
          nxt_cur.st = CGC_ST_RUN;
        end else begin
          nxt_cur.cnt = cur_ff.cnt - 1'b1;
        end
      end
      CGC_ST_RUN: begin
        if (stop_req) begin
          nxt_cur.st = CGC_ST_STOP;
        end
      end
      CGC_ST_STOP: begin
        // Software is trusted to have picked a wait long enough for its resonator
        if (wake_event) begin
          if (is_crystal) begin
            nxt_cur.st  = CGC_ST_START;
            nxt_cur.cnt = wait_load(cur_ff.wait_sel);
          end else begin
            nxt_cur.st  = CGC_ST_RUN;
          end
        end
      end
      default: begin
        nxt_cur.st = CGC_ST_BOOT;
      end
    endcase

    // Outputs follow the next state so they change with it
    nxt_cur.sys_halt = (nxt_cur.st == CGC_ST_STOP);
    nxt_cur.cpu_hold = (nxt_cur.st != CGC_ST_RUN);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cur_ff          <= '0;
      cur_ff.st       <= CGC_ST_BOOT;
      cur_ff.cpu_div  <= CGC_RST_CPU_CLOCK_DIVIDER[CGC_CPU_DIVIDE_BIT];
      cur_ff.per_div  <= CGC_RST_PERIPHERAL_CLOCK_DIVIDER[CGC_PERIPH_DIVIDE_LOW+:2];
      cur_ff.per_exp  <= CGC_RST_PERIPHERAL_CLOCK_DIVIDER[CGC_PERIPH_DIVIDE_LOW+:2];
      cur_ff.cpu_exp  <= {1'b0, CGC_RST_PERIPHERAL_CLOCK_DIVIDER[CGC_PERIPH_DIVIDE_LOW+:2]} +
                         (CGC_RST_CPU_CLOCK_DIVIDER[CGC_CPU_DIVIDE_BIT] ? CGC_CPU_EXTRA_EXP : 3'h0);
      cur_ff.ls_halt  <= CGC_RST_LOWSPEED_OSC_CONTROL[CGC_LOWSPEED_HALT_BIT];
      // Field is undefined to software; hardware still needs a known value
      cur_ff.wait_sel <= CGC_RST_WAIT_SELECT;
      cur_ff.cpu_hold <= 1'b1;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler, stopped while the CPU is held

  cgc_prescaler u_prescaler (
    .clk           (clk),
    .sys_rst       (sys_rst),
    .run           (!cur_ff.cpu_hold),
    .cpu_exp       (cur_ff.cpu_exp),
    .periph_exp    (cur_ff.per_exp),
    .cpu_clk_en    (cpu_clk_en),
    .periph_clk_en (periph_clk_en)
  );

  // Outputs other than the clock enables come straight from the state register
  assign bus_rdata_ff          = cur_ff.rdata;
  assign bus_rvalid_ff         = cur_ff.rvalid;
  assign sys_osc_halt_ff       = cur_ff.sys_halt;
  assign lowspeed_osc_halt_ff  = cur_ff.ls_osc_halt;
  assign wdt_force_lowspeed_ff = cur_ff.wdt_force;
  assign cpu_hold_ff           = cur_ff.cpu_hold;
  assign div_prohibited_ff     = cur_ff.div_bad;

endmodule

/* File: test/cgc_sva.sv */
/*
  Checker of the clock generator control block, bound to its top module.
  Assumes one clock domain and the bus and stop timing of the hand-over.
*/
`timescale 1ns/1ps
module cgc_sva
  import cgc_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // Register bus
  input wire logic [15:0] bus_addr,
  input wire logic        bus_wr,
  input wire logic        bus_rd,
  input wire logic [7:0]  bus_wdata,
  input wire logic [7:0]  bus_wmask,
  input wire logic [7:0]  bus_rdata_ff,
  input wire logic        bus_rvalid_ff,
  // Option byte and stop sequencing
  input wire logic [1:0]  opt_clk_src,
  input wire logic        opt_lowspeed_locked,
  input wire logic        stop_req,
  input wire logic        wake_event,
  input wire logic        osc_running,
  // Control outputs
  input wire logic        sys_osc_halt_ff,
  input wire logic        lowspeed_osc_halt_ff,
  input wire logic        wdt_force_lowspeed_ff,
  input wire logic        cpu_hold_ff,
  input wire logic        div_prohibited_ff
);
  // Single domain, so clock and reset are given once
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  ////////////////////////////////////////////////////////////////////////////
  // Guard against $past seeing reset-time values
  wdt_source_a: assert property (!$past(sys_rst) |-> wdt_force_lowspeed_ff == $past(opt_lowspeed_locked))
    else $error("watchdog source does not follow lock option");
  lowspeed_lock_a: assert property (!$past(sys_rst) && $past(opt_lowspeed_locked) |-> !lowspeed_osc_halt_ff)
    else $error("locked low-speed oscillator halted");
  read_answer_a: assert property (bus_rd |=> bus_rvalid_ff)
    else $error("read not answered next cycle");
  idle_data_a: assert property (!bus_rvalid_ff |-> bus_rdata_ff == 8'h00)
    else $error("read data not zero outside read");
  unused_bits_a: assert property (bus_rvalid_ff |-> bus_rdata_ff[7:2] == 6'h00)
    else $error("unimplemented bits read nonzero");
  stop_halt_a: assert property (stop_req && !cpu_hold_ff |=> sys_osc_halt_ff && cpu_hold_ff)
    else $error("stop did not halt oscillator");
  wake_direct_a: assert property (sys_osc_halt_ff && wake_event && opt_clk_src != CGC_SRC_CRYSTAL
    |=> !sys_osc_halt_ff && !cpu_hold_ff) else $error("non-crystal wake not immediate");
  wake_crystal_a: assert property (sys_osc_halt_ff && wake_event && opt_clk_src == CGC_SRC_CRYSTAL
    |=> !sys_osc_halt_ff && cpu_hold_ff) else $error("crystal wake skipped wait");
  start_hold_a: assert property (cpu_hold_ff && !sys_osc_halt_ff && !osc_running && opt_clk_src == CGC_SRC_CRYSTAL
    |=> cpu_hold_ff) else $error("cpu released before oscillation");
  div_flag_a: assert property (bus_wr && bus_addr == CGC_ADDR_PERIPHERAL_CLOCK_DIVIDER && bus_wmask == CGC_FULL_BYTE
    && bus_wdata[1:0] == CGC_PDIV_PROHIBITED |-> ##[1:2] div_prohibited_ff) else $error("prohibited code not flagged");
endmodule

bind cgc_clock_generator_control cgc_sva u_sva (.clk, .sys_rst, .bus_addr, .bus_wr, .bus_rd, .bus_wdata,
  .bus_wmask, .bus_rdata_ff, .bus_rvalid_ff, .opt_clk_src, .opt_lowspeed_locked, .stop_req, .wake_event,
  .osc_running, .sys_osc_halt_ff, .lowspeed_osc_halt_ff, .wdt_force_lowspeed_ff, .cpu_hold_ff, .div_prohibited_ff);

/* File: test/cgc_resonator_model.sv */
/*
  Resonator model: reports oscillation a set number of cycles after the
  block stops halting it. Assumes the bench sets start_dly.
*/
`timescale 1ns/1ps
module cgc_resonator_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Control from the block, startup delay from the bench
  input  wire logic       sys_osc_halt_ff,
  input  wire logic [7:0] start_dly,
  // Oscillator status
  output logic            osc_running
);
  int cnt;

  // Dead while halted; startup interval before oscillation
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst || sys_osc_halt_ff) begin
      cnt = 0;
      osc_running <= 1'b0;
    end else if (cnt >= start_dly) begin
      osc_running <= 1'b1;
    end else begin
      cnt++;
    end
  end
endmodule

/* File: test/cgc_clock_generator_control_tb.sv */
/*
  Testbench of the clock generator control block with a resonator model.
  Assumes the bound checker and shortened wait counts 4, 6, 8 and 10.
*/
`timescale 1ns/1ps
module cgc_clock_generator_control_tb
  import cgc_pkg::*;
;
  localparam int unsigned WN [4] = '{4, 6, 8, 10};
  logic        clk, sys_rst, bus_wr, bus_rd, locked, stop_req, wake_event;
  logic        rvalid, osc_running, sys_halt, ls_halt, wdt_force, hold, prohib, cpu_en, per_en;
  logic [15:0] bus_addr;
  logic [7:0]  bus_wdata, bus_wmask, start_dly, rdata;
  logic [1:0]  src, rst_wait;
  int          bad_count, n_checks, cycles;
  // Register model: address, implemented bits, value
  logic [15:0] adr [4] = '{CGC_ADDR_LOWSPEED_OSC_CONTROL, CGC_ADDR_PERIPHERAL_CLOCK_DIVIDER,
                           CGC_ADDR_STOP_WAKE_WAIT_SELECT, CGC_ADDR_CPU_CLOCK_DIVIDER};
  logic [7:0]  imp [4] = '{8'h01, 8'h03, 8'h03, 8'h02};
  int          mdl [4] = '{0, 2, 0, 2};
  // Divider table; last row is prohibited and keeps the previous ratio
  logic [7:0]  pp [7]  = '{0, 1, 0, 2, 1, 2, 3};
  logic        pc [7]  = '{0, 0, 1, 0, 1, 1, 1};
  int          ce [7]  = '{0, 1, 2, 2, 3, 4, 4};
  int          pe [7]  = '{0, 1, 0, 2, 1, 2, 2};

  cgc_clock_generator_control #(.WAIT_CNT_CODE0(WN[0]), .WAIT_CNT_CODE1(WN[1]), .WAIT_CNT_CODE2(WN[2]),
    .WAIT_CNT_CODE3(WN[3])) u_dut (.clk(clk), .sys_rst(sys_rst), .bus_addr(bus_addr), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_wmask(bus_wmask), .bus_rdata_ff(rdata), .bus_rvalid_ff(rvalid),
    .opt_clk_src(src), .opt_lowspeed_locked(locked), .opt_reset_wait_sel(rst_wait), .stop_req(stop_req),
    .wake_event(wake_event), .osc_running(osc_running), .sys_osc_halt_ff(sys_halt),
    .lowspeed_osc_halt_ff(ls_halt), .wdt_force_lowspeed_ff(wdt_force), .cpu_hold_ff(hold),
    .div_prohibited_ff(prohib), .cpu_clk_en(cpu_en), .periph_clk_en(per_en));
  cgc_resonator_model u_res (.clk(clk), .sys_rst(sys_rst), .sys_osc_halt_ff(sys_halt),
    .start_dly(start_dly), .osc_running(osc_running));

  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("Checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check_val(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // Every drive lands 2 ns after an edge, never on it
  task automatic tick(input int n);
    repeat (n) @(posedge clk) #2;
  endtask
  // Idle cycle after each access keeps strobes from toggling twice in one step
  task automatic bus_write(input logic [15:0] a, input logic [7:0] d, input logic [7:0] m);
    bus_addr = a;
    bus_wdata = d;
    bus_wmask = m;
    bus_wr = 1'b1;
    tick(1);
    bus_wr = 1'b0;
    tick(1);
  endtask
  task automatic bus_read(input logic [15:0] a, output logic [7:0] d);
    bus_addr = a;
    bus_rd = 1'b1;
    tick(1);
    d = rdata;
    check_val("read valid", rvalid, 1'b1);
    bus_rd = 1'b0;
    tick(1);
  endtask
  task automatic pulse(input bit w);
    if (w) wake_event = 1'b1;
    else stop_req = 1'b1;
    tick(1);
    wake_event = 1'b0;
    stop_req = 1'b0;
    tick(1);
  endtask
  task automatic measure(output int n);
    n = 0;
    while (hold === 1'b1 && n < 500) begin
      tick(1);
      n++;
    end
  endtask
  task automatic do_reset(input logic [1:0] s, input logic [1:0] w, output int n);
    src = s;
    rst_wait = w;
    sys_rst = 1'b1;
    tick(10);
    sys_rst = 1'b0;
    measure(n);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      $display("Error run time expected end seen hang");
      complete_run();
    end
  end

  // Main sequence
  initial begin
    int i, d, m, nc, np, r0;
    int ms [5];
    logic [7:0] rd;
    {sys_rst, bus_wr, bus_rd, locked, stop_req, wake_event} = 6'h20;
    {bus_addr, bus_wdata, bus_wmask, src, rst_wait} = '0;
    start_dly = 8'h02;
    void'($urandom(85));
    repeat (10) @(posedge clk);
    #2 sys_rst = 1'b0;
    tick(2);
    for (i = 0; i < 4; i++) begin
      bus_read(adr[i], rd);
      if (i != 2) check_val("reset value", rd, mdl[i]);
    end
    bus_write(16'hFF00, 8'hFF, 8'hFF);
    bus_read(16'hFF00, rd);
    check_val("unmapped", rd, 8'h00);
    // Random byte and bit writes; wait select keeps only whole bytes
    mdl[2] = -1;
    for (int k = 0; k < 20; k++) begin
      i = $urandom % 4;
      d = $urandom % 256;
      m = ($urandom % 2) ? 8'hFF : 8'h01 << ($urandom % 8);
      bus_write(adr[i], d[7:0], m[7:0]);
      if (i != 2 || m == 8'hFF) mdl[i] = ((mdl[i] & ~m) | (d & m)) & imp[i];
      bus_read(adr[i], rd);
      if (mdl[i] >= 0) check_val("register", rd, mdl[i]);
    end
    for (i = 0; i < 4; i++) begin
      locked = i[1];
      bus_write(CGC_ADDR_LOWSPEED_OSC_CONTROL, {7'h00, i[0]}, 8'hFF);
      tick(1);
      check_val("lowspeed halt", ls_halt, i[0] & ~i[1]);
      check_val("wdt source", wdt_force, i[1]);
    end
    locked = 1'b0;
    for (i = 0; i < 8; i++) begin
      bus_write(CGC_ADDR_PERIPHERAL_CLOCK_DIVIDER, (i == 7) ? 8'h02 : pp[i], 8'hFF);
      bus_write(CGC_ADDR_CPU_CLOCK_DIVIDER, {6'h00, pc[i % 7], 1'b0}, 8'hFF);
      tick(2);
      check_val("prohibited flag", prohib, i == 6);
      if (i == 7) break;
      {nc, np} = '0;
      repeat (64) begin
        tick(1);
        nc += cpu_en;
        np += per_en;
      end
      check_val("cpu enables", nc, 64 >> ce[i]);
      check_val("periph enables", np, 64 >> pe[i]);
    end
    // Non-crystal sources release stop without a wait
    for (i = 0; i < 3; i += 2) begin
      do_reset(i[1:0], 2'h0, r0);
      pulse(1'b1);
      check_val("wake in run", hold, 1'b0);
      pulse(1'b0);
      check_val("stop", {sys_halt, hold}, 2'h3);
      pulse(1'b1);
      check_val("wake", {sys_halt, hold}, 2'h0);
    end
    do_reset(CGC_SRC_CRYSTAL, 2'h0, r0);
    do_reset(CGC_SRC_CRYSTAL, 2'h2, d);
    check_val("reset wait", d - r0, WN[2] - WN[0]);
    for (i = 0; i < 5; i++) begin
      start_dly = (i == 4) ? 8'h07 : 8'h02;
      bus_write(CGC_ADDR_STOP_WAKE_WAIT_SELECT, 8'(i % 4), 8'hFF); // wait counts only after startup
      pulse(1'b0);
      pulse(1'b1);
      measure(ms[i]);
      check_val("stop wait", ms[i] - ms[0], (i == 4) ? 5 : WN[i % 4] - WN[0]);
    end
    check_val("wait floor", ms[0] >= WN[0] + 2, 1'b1);
    complete_run();
  end
endmodule
